// >>> vpw_pkg.sv
// package for the vpw symbol and crc codec: times, counts, register map, crc step
// assumes a 40 MHz core clock and word-wide ahb-lite register access
package vpw_pkg;

   // ************************************************************
   // clock and symbol times (microseconds, nominal at 10.4 kbps)
   // ************************************************************
   localparam int unsigned CLK_MHZ = 40;
   localparam int unsigned T_SHORT_US = 64;
   localparam int unsigned T_LONG_US = 128;
   localparam int unsigned T_SOF_US = 200;
   localparam int unsigned T_EOD_US = 200;
   localparam int unsigned T_EOF_EXTRA_US = 80;
   localparam int unsigned T_EOF_US = T_EOD_US + T_EOF_EXTRA_US;
   localparam int unsigned T_IFS_SEP_US = 20;
   localparam int unsigned T_IFS_US = T_EOF_US + T_IFS_SEP_US;
   localparam int unsigned T_BREAK_US = 240;
   // receive windows abut: one window's maximum is the next one's minimum
   localparam int unsigned T_BIT_MIN_US = 34;
   localparam int unsigned T_BIT_MID_US = 96;
   localparam int unsigned T_BIT_MAX_US = 164;
   localparam int unsigned CNT_W = 16;
   localparam logic [7:0] RESYNC_CYC = 8'h68;

   // ************************************************************
   // crc
   // ************************************************************
   localparam logic [7:0] CRC_POLY = 8'h1D;
   localparam logic [7:0] CRC_INIT = 8'hFF;
   localparam logic [7:0] CRC_RESIDUE = 8'hC4;

   // ************************************************************
   // register map and fields
   // ************************************************************
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STATUS = 12'h004;
   localparam logic [11:0] ADDR_DATA = 12'h008;
   localparam int unsigned CTRL_FAST = 0;
   localparam int unsigned DATA_LAST = 8;
   localparam int unsigned SV_RX_FULL = 0;
   localparam int unsigned SV_TX_EMPTY = 1;
   localparam int unsigned SV_EOF = 2;
   localparam int unsigned SV_CRC_ERR = 3;
   localparam int unsigned SV_INVALID = 4;
   localparam int unsigned SV_TX_ERR = 5;
   localparam int unsigned SV_IDLE = 6;
   localparam int unsigned SV_TX_BUSY = 7;
   localparam logic [7:0] SV_STICKY = 8'h3D;

   typedef enum logic [1:0] {TX_IDLE, TX_SOF, TX_BIT} vpw_tx_type;

   function automatic logic [7:0] vpw_crc_bit(input logic [7:0] crc, input logic din);
      vpw_crc_bit = {crc[6:0], 1'b0} ^ ((crc[7] ^ din) ? CRC_POLY : 8'h00);
   endfunction : vpw_crc_bit

endpackage : vpw_pkg

// >>> vpw_symbol_crc_codec.sv
// vpw symbol encoder/decoder with frame check, behind an ahb-lite register slave
// assumes rx_i is the filtered receive line from the transceiver, high = active
// How it works
// - frame check uses x^8+x^4+x^3+x^2+1 serially over bytes after start-of-frame
// - remainder preset to all ones at the start of every sent or received frame
// - after last data byte send inverted remainder, most significant bit first
// - receive residue over data and check byte must be C4, else crc error
// - 200 us passive after a falling edge is end-of-data, no flag
// - passive reaching 280 us is end-of-frame and sets its flag
// - nobody starts a frame before 300 us passive total
// - rising edge while waiting resyncs; write within 104 clocks still sends
// - resynchronise to any start-of-frame that begins during separation
// - never drive a break; only detect one
// - break while sending is a transmit error and releases the bus
// - break while receiving sets invalid symbol and drops the frame
// - break while receiving also clears fast receive enable
// - passive over 300 us is idle; sending may start at once
// - each bit has one transition, levels alternate, 64 or 128 us
// - zero is 64 us passive or 128 us active
// - one is 128 us passive or 64 us active
// - 200 us active start-of-frame so each byte begins passive
// - active period of 240 us or more is a break
// - with no response, 80 us more after end-of-data completes the frame
// - receive resolves to one clock, four clocks at quad speed; windows abut without gaps
// - send at least one data byte plus check byte, msb first
// - pending send starts at a rising edge after a valid end-of-frame
//
// Chosen here: the register offsets and the AHB-Lite slave port.
`timescale 1ns/100ps
module vpw_symbol_crc_codec
   import vpw_pkg::*;
#(
   parameter logic [CNT_W-1:0] SHORT_CYC = CNT_W'(T_SHORT_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] LONG_CYC = CNT_W'(T_LONG_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] SOF_CYC = CNT_W'(T_SOF_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] EOD_CYC = CNT_W'(T_EOD_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] EOF_CYC = CNT_W'(T_EOF_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] IFS_CYC = CNT_W'(T_IFS_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] BREAK_CYC = CNT_W'(T_BREAK_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] MIN_CYC = CNT_W'(T_BIT_MIN_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] MID_CYC = CNT_W'(T_BIT_MID_US * CLK_MHZ),
   parameter logic [CNT_W-1:0] MAX_CYC = CNT_W'(T_BIT_MAX_US * CLK_MHZ)
)
(
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic rx_i,
   output logic tx_o
);

   // ************************************************************
   // bus slave
   // ************************************************************
   logic acc_ph;
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic wr_ctrl, wr_status, wr_data, rd_data;
   logic fast_q;
   logic [7:0] sv_q, sv_set, sv_clr, sv_rd;
   logic [7:0] rx_data_q;
   logic tx_pend_q;
   vpw_tx_type tx_st_q;

   // only whole-word single transfers are issued, so hsize needs no decode
   assign acc_ph = hsel_i && htrans_i[1] && hready_i;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = hrdata_q;
   assign wr_ctrl = wr_pend_q && (wr_addr_q == ADDR_CTRL);
   assign wr_status = wr_pend_q && (wr_addr_q == ADDR_STATUS);
   assign wr_data = wr_pend_q && (wr_addr_q == ADDR_DATA);
   assign rd_data = acc_ph && !hwrite_i && (haddr_i[11:0] == ADDR_DATA);

   always_comb
   begin
      sv_rd = sv_q & SV_STICKY;
      sv_rd[SV_TX_EMPTY] = !tx_pend_q;
      sv_rd[SV_TX_BUSY] = (tx_st_q != TX_IDLE);
      sv_rd[SV_IDLE] = 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
      end
      else
      begin
         wr_pend_q <= acc_ph && hwrite_i;
         wr_addr_q <= haddr_i[11:0];
      end
   end

   logic bus_idle;

   // read data is captured in the address phase so the data phase needs no wait
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         hrdata_q <= 32'h0000_0000;
      else if (acc_ph && !hwrite_i)
      begin
         unique case (haddr_i[11:0])
            ADDR_CTRL: hrdata_q <= {31'h0000_0000, fast_q};
            ADDR_STATUS: hrdata_q <= {24'h00_0000, sv_rd[7], bus_idle, sv_rd[5:0]};
            ADDR_DATA: hrdata_q <= {24'h00_0000, rx_data_q};
            default: hrdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // receive: synchroniser, duration counter, classification
   // ************************************************************
   logic rx_s1_q, rx_s2_q, rx_lvl_q;
   logic [CNT_W-1:0] rx_cnt_q, rx_step;
   logic edge_det, rise, act_end, pas_end;
   logic in_frame_q, eof_wait_q, eof_seen_q, brk_q;
   logic [7:0] rx_sh_q, rx_crc_q;
   logic [2:0] rx_bits_q;
   logic sof_evt, bit_evt, bit_val, bad_evt, eod_evt, eof_evt, brk_evt;
   logic cnt_bit_ok;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         rx_s1_q <= 1'b0;
         rx_s2_q <= 1'b0;
         rx_lvl_q <= 1'b0;
      end
      else
      begin
         rx_s1_q <= rx_i;
         rx_s2_q <= rx_s1_q;
         rx_lvl_q <= rx_s2_q;
      end
   end

   assign edge_det = rx_s2_q != rx_lvl_q;
   assign rise = edge_det && rx_s2_q;
   assign act_end = edge_det && rx_lvl_q;
   assign pas_end = edge_det && !rx_lvl_q;
   // quad speed counts four per clock so every window shrinks by four
   assign rx_step = fast_q ? CNT_W'(4) : CNT_W'(1);
   assign cnt_bit_ok = (rx_cnt_q >= MIN_CYC) && (rx_cnt_q < MAX_CYC);
   // edges during separation simply restart the count: this is the resync
   assign sof_evt = act_end && (rx_cnt_q >= MAX_CYC) && (rx_cnt_q < BREAK_CYC);
   assign bit_evt = in_frame_q && edge_det && cnt_bit_ok;
   // passive: long is one; active: short is one
   assign bit_val = rx_lvl_q ? (rx_cnt_q < MID_CYC) : (rx_cnt_q >= MID_CYC);
   assign bad_evt = in_frame_q && ((edge_det && (rx_cnt_q < MIN_CYC)) ||
                                   (pas_end && (rx_cnt_q >= MAX_CYC)));
   assign eod_evt = in_frame_q && !rx_s2_q && !edge_det && (rx_cnt_q >= EOD_CYC);
   assign eof_evt = eof_wait_q && !rx_s2_q && !edge_det && (rx_cnt_q >= EOF_CYC);
   assign brk_evt = rx_s2_q && !edge_det && !brk_q && (rx_cnt_q >= BREAK_CYC);
   assign bus_idle = !rx_s2_q && (rx_cnt_q >= IFS_CYC);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         rx_cnt_q <= '0;
      else if (edge_det)
         rx_cnt_q <= rx_step;
      else if (rx_cnt_q <= IFS_CYC)
         rx_cnt_q <= rx_cnt_q + rx_step;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         in_frame_q <= 1'b0;
         eof_wait_q <= 1'b0;
         brk_q <= 1'b0;
         rx_bits_q <= 3'h0;
         rx_sh_q <= 8'h00;
         rx_crc_q <= CRC_INIT;
         rx_data_q <= 8'h00;
      end
      else
      begin
         brk_q <= brk_evt || (brk_q && !edge_det);
         if (sof_evt)
         begin
            in_frame_q <= 1'b1;
            eof_wait_q <= 1'b0;
            rx_bits_q <= 3'h0;
            rx_crc_q <= CRC_INIT;
         end
         else if (bad_evt || (brk_evt && in_frame_q))
            in_frame_q <= 1'b0;
         else if (eod_evt)
         begin
            in_frame_q <= 1'b0;
            eof_wait_q <= 1'b1;
         end
         else if (bit_evt)
         begin
            rx_crc_q <= vpw_crc_bit(rx_crc_q, bit_val);
            rx_sh_q <= {rx_sh_q[6:0], bit_val};
            rx_bits_q <= rx_bits_q + 3'h1;
            if (rx_bits_q == 3'h7)
               rx_data_q <= {rx_sh_q[6:0], bit_val};
         end
         if (eof_evt || edge_det)
            eof_wait_q <= 1'b0;
      end
   end

   // ************************************************************
   // end-of-frame memory and resync window for a pending send
   // ************************************************************
   logic [7:0] since_rise_q;
   logic win_open;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         eof_seen_q <= 1'b0;
         since_rise_q <= 8'hFF;
      end
      else
      begin
         if (eof_evt)
            eof_seen_q <= 1'b1;
         else if (since_rise_q > RESYNC_CYC && since_rise_q != 8'hFF)
            eof_seen_q <= 1'b0;
         if (rise)
            since_rise_q <= 8'h00;
         else if (since_rise_q != 8'hFF)
            since_rise_q <= since_rise_q + 8'h01;
      end
   end

   // a start is allowed on the rising edge itself or up to 105 clocks after it
   assign win_open = eof_seen_q && (rise || (since_rise_q <= RESYNC_CYC));

   // ************************************************************
   // status flags and control
   // ************************************************************
   always_comb
   begin
      sv_set = 8'h00;
      sv_set[SV_RX_FULL] = bit_evt && !sof_evt && (rx_bits_q == 3'h7);
      sv_set[SV_EOF] = eof_evt;
      sv_set[SV_CRC_ERR] = eod_evt && (rx_crc_q != CRC_RESIDUE);
      sv_set[SV_INVALID] = bad_evt || (brk_evt && in_frame_q) ||
                           (eod_evt && (rx_bits_q != 3'h0));
      sv_set[SV_TX_ERR] = 1'b0;
      sv_clr = wr_status ? hwdata_i[7:0] : 8'h00;
      sv_clr[SV_RX_FULL] = rd_data;
   end

   logic tx_err_set;

   // a hardware event in the same cycle as a clear keeps its flag set
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         sv_q <= 8'h00;
      else
      begin
         sv_q <= ((sv_q & ~sv_clr) | sv_set) & SV_STICKY;
         if (tx_err_set)
            sv_q[SV_TX_ERR] <= 1'b1;
      end
   end

   // the break exit wins over a software write to the same bit
   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
         fast_q <= 1'b0;
      else if (brk_evt && in_frame_q)
         fast_q <= 1'b0;
      else if (wr_ctrl)
         fast_q <= hwdata_i[CTRL_FAST];
   end

   // ************************************************************
   // transmit
   // ************************************************************
   logic [7:0] tx_buf_q, tx_sh_q, tx_crc_q, crc_n;
   logic tx_buf_last_q, tx_last_q, tx_chk_q, tx_lvl_q, tx_q, tx_load;
   logic [2:0] tx_bit_q;
   logic [CNT_W-1:0] tx_cnt_q, tx_tgt;
   logic tx_start, bit_end;

   assign tx_o = tx_q;
   // msb goes first; long pulse when bit and level differ from passive zero
   assign tx_tgt = (tx_sh_q[7] ^ tx_lvl_q) ? LONG_CYC : SHORT_CYC;
   assign bit_end = (tx_st_q == TX_BIT) && ((tx_cnt_q + CNT_W'(1)) >= tx_tgt);
   assign crc_n = tx_chk_q ? tx_crc_q : vpw_crc_bit(tx_crc_q, tx_sh_q[7]);
   assign tx_start = tx_pend_q && (tx_st_q == TX_IDLE) && (bus_idle || win_open);
   assign tx_load = bit_end && (tx_bit_q == 3'h0) && !tx_chk_q && !tx_last_q && tx_pend_q;
   assign tx_err_set = ((tx_st_q != TX_IDLE) && brk_evt) ||
                       (bit_end && (tx_bit_q == 3'h0) && !tx_chk_q && !tx_last_q && !tx_pend_q);

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         tx_pend_q <= 1'b0;
         tx_buf_q <= 8'h00;
         tx_buf_last_q <= 1'b0;
      end
      else if (wr_data)
      begin
         tx_pend_q <= 1'b1;
         tx_buf_q <= hwdata_i[7:0];
         tx_buf_last_q <= hwdata_i[DATA_LAST];
      end
      else if (tx_start || tx_load)
         tx_pend_q <= 1'b0;
   end

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i)
      begin
         tx_st_q <= TX_IDLE;
         tx_q <= 1'b0;
         tx_cnt_q <= '0;
         tx_sh_q <= 8'h00;
         tx_bit_q <= 3'h7;
         tx_crc_q <= CRC_INIT;
         tx_lvl_q <= 1'b0;
         tx_last_q <= 1'b0;
         tx_chk_q <= 1'b0;
      end
      else if ((tx_st_q != TX_IDLE) && brk_evt)
      begin
         tx_st_q <= TX_IDLE;
         tx_q <= 1'b0;
      end
      else
      begin
         unique case (tx_st_q)
            TX_IDLE:
            begin
               if (tx_start)
               begin
                  tx_st_q <= TX_SOF;
                  tx_q <= 1'b1;
                  // align with a start-of-frame another node already began
                  tx_cnt_q <= (bus_idle || rise) ? '0 : CNT_W'(since_rise_q);
                  tx_sh_q <= tx_buf_q;
                  tx_last_q <= tx_buf_last_q;
                  tx_crc_q <= CRC_INIT;
                  tx_chk_q <= 1'b0;
                  tx_bit_q <= 3'h7;
               end
            end
            TX_SOF:
            begin
               // sof stays below the break length, so a break is never driven
               if ((tx_cnt_q + CNT_W'(1)) >= SOF_CYC)
               begin
                  tx_st_q <= TX_BIT;
                  tx_lvl_q <= 1'b0;
                  tx_q <= 1'b0;
                  tx_cnt_q <= '0;
               end
               else
                  tx_cnt_q <= tx_cnt_q + CNT_W'(1);
            end
            TX_BIT:
            begin
               if (bit_end)
               begin
                  tx_cnt_q <= '0;
                  tx_crc_q <= crc_n;
                  tx_bit_q <= tx_bit_q - 3'h1;
                  tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                  tx_lvl_q <= !tx_lvl_q;
                  tx_q <= !tx_lvl_q;
                  if (tx_bit_q == 3'h0)
                  begin
                     // byte boundaries always return to passive, so level alternates
                     if (tx_chk_q || (!tx_last_q && !tx_pend_q))
                     begin
                        tx_st_q <= TX_IDLE;
                        tx_q <= 1'b0;
                     end
                     else if (tx_last_q)
                     begin
                        tx_sh_q <= ~crc_n;
                        tx_chk_q <= 1'b1;
                     end
                     else
                     begin
                        tx_sh_q <= tx_buf_q;
                        tx_last_q <= tx_buf_last_q;
                     end
                  end
               end
               else
                  tx_cnt_q <= tx_cnt_q + CNT_W'(1);
            end
         endcase
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   logic [CNT_W-1:0] act_run_q;

   always_ff @(posedge core_clk_i)
   begin
      if (reset_i || !tx_q)
         act_run_q <= '0;
      else if (act_run_q != '1)
         act_run_q <= act_run_q + CNT_W'(1);
   end

   property p_no_break;
      @(posedge core_clk_i) disable iff (reset_i) act_run_q < BREAK_CYC;
   endproperty
   a_no_break: assert property (p_no_break) else $error("transmitter held active too long");

   property p_tx_preset;
      @(posedge core_clk_i) disable iff (reset_i)
         tx_start && !brk_evt |=> (tx_crc_q == CRC_INIT) && tx_q;
   endproperty
   a_tx_preset: assert property (p_tx_preset) else $error("tx crc not preset at start");

   property p_brk_tx;
      @(posedge core_clk_i) disable iff (reset_i)
         brk_evt && (tx_st_q != TX_IDLE) |=> !tx_q && (tx_st_q == TX_IDLE) && sv_q[SV_TX_ERR];
   endproperty
   a_brk_tx: assert property (p_brk_tx) else $error("break did not stop transmit");

   property p_brk_rx;
      @(posedge core_clk_i) disable iff (reset_i)
         brk_evt && in_frame_q |=> sv_q[SV_INVALID] && !in_frame_q;
   endproperty
   a_brk_rx: assert property (p_brk_rx) else $error("break did not drop frame");

   property p_brk_fast;
      @(posedge core_clk_i) disable iff (reset_i)
         brk_evt && in_frame_q && fast_q |=> !fast_q;
   endproperty
   a_brk_fast: assert property (p_brk_fast) else $error("fast receive not cleared");

   property p_crc_chk;
      @(posedge core_clk_i) disable iff (reset_i)
         eod_evt && (rx_crc_q != CRC_RESIDUE) |=> sv_q[SV_CRC_ERR];
   endproperty
   a_crc_chk: assert property (p_crc_chk) else $error("crc error not flagged");

   property p_eod_noflag;
      @(posedge core_clk_i) disable iff (reset_i)
         eod_evt && !sv_q[SV_EOF] |=> !sv_q[SV_EOF];
   endproperty
   a_eod_noflag: assert property (p_eod_noflag) else $error("flag set on end-of-data");

   property p_eof;
      @(posedge core_clk_i) disable iff (reset_i)
         eof_evt |=> sv_q[SV_EOF] && eof_seen_q;
   endproperty
   a_eof: assert property (p_eof) else $error("end-of-frame not flagged");

   property p_sof_passive;
      @(posedge core_clk_i) disable iff (reset_i)
         (tx_st_q == TX_SOF) && !brk_evt ##1 (tx_st_q == TX_BIT) |-> !tx_q && !tx_lvl_q;
   endproperty
   a_sof_passive: assert property (p_sof_passive) else $error("first bit not passive");

   property p_bit_len;
      @(posedge core_clk_i) disable iff (reset_i)
         (tx_st_q == TX_BIT) && $changed(tx_q) |-> ($past(tx_cnt_q) + CNT_W'(1)) >= $past(tx_tgt);
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("tx bit changed early");

   property p_start_ok;
      @(posedge core_clk_i) disable iff (reset_i)
         $rose(tx_st_q == TX_SOF) |-> $past(bus_idle) || $past(win_open);
   endproperty
   a_start_ok: assert property (p_start_ok) else $error("send started inside separation");

endmodule : vpw_symbol_crc_codec

// >>> vpw_node_model.sv
// far-side vpw node: wired-or bus joining the codec's drive and its own
// assumes high = active on both lines and one clock per microsecond of counts
`timescale 1ns/100ps
module vpw_node_model
(
   input wire logic core_clk_i,
   input wire logic tx_i,
   output logic rx_o
);
   logic drive_q = 1'b0;
   // active dominates, so the codec hears its own frame and our breaks
   assign rx_o = drive_q | tx_i;
   task automatic hold(input logic lvl, input int n);
      drive_q <= lvl;
      repeat (n) @(posedge core_clk_i);
   endtask : hold
   // n bits msb first after a start-of-frame; dv shortens times for quad speed
   task automatic send(input logic [15:0] b, input int n, input logic brk, input int dv);
      logic lvl;
      lvl = 1'b0;
      hold(1'b1, 200 / dv);
      for (int i = 15; i > 15 - n; i--)
      begin
         hold(lvl, ((b[i] == lvl) ? 64 : 128) / dv);
         lvl = ~lvl;
      end
      if (brk)
         hold(1'b1, 300);
      hold(1'b0, 1);
   endtask : send
endmodule : vpw_node_model

// >>> vpw_symbol_crc_codec_tb.sv
// self-checking bench: ahb-lite master, partner node, tx_o decoder with queue
// assumes small counts of one clock per microsecond
`timescale 1ns/100ps
module vpw_symbol_crc_codec_tb
   import vpw_pkg::*;
;
   logic clk, rst, hsel, hwrite, mon_en, rx, tx, hrdy, hresp, lvl;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [15:0] b;
   logic [7:0] sh;
   logic [7:0] exp_q[$];
   int error_cnt = 0, n_compared = 0, len = 0, nb = 0, cyc = 0;
   int seed = 32'hd152ca24;
   // counts scaled to one clock per microsecond so a frame fits a short run
   vpw_symbol_crc_codec #(.SHORT_CYC(CNT_W'(T_SHORT_US)), .LONG_CYC(CNT_W'(T_LONG_US)),
      .SOF_CYC(CNT_W'(T_SOF_US)), .EOD_CYC(CNT_W'(T_EOD_US)), .EOF_CYC(CNT_W'(T_EOF_US)),
      .IFS_CYC(CNT_W'(T_IFS_US)), .BREAK_CYC(CNT_W'(T_BREAK_US)),
      .MIN_CYC(CNT_W'(T_BIT_MIN_US)), .MID_CYC(CNT_W'(T_BIT_MID_US)),
      .MAX_CYC(CNT_W'(T_BIT_MAX_US))) vpw_symbol_crc_codec_i (
      .core_clk_i(clk), .reset_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hrdy),
      .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .rx_i(rx), .tx_o(tx));
   vpw_node_model vpw_node_model_i (.core_clk_i(clk), .tx_i(tx), .rx_o(rx));
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] expd);
      n_compared++;
      if (seen !== expd)
      begin
         error_cnt++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
      end
   endtask : check
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1; haddr <= {20'h00000, a}; hwrite <= w; htrans <= 2'h2;
      hsize <= 3'h2;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
      check(hresp, 1'b0);
   endtask : ahb
   // own reference: preset to ones, serial over the bytes, inverted at the end
   function automatic logic [7:0] crc8(input logic [15:0] d, input int n);
      logic [7:0] c = 8'hFF;
      for (int i = n - 1; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
      return ~c;
   endfunction : crc8
   // ************************************************************
   // tx_o decoder: a segment is classified when its level ends
   // ************************************************************
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         print_verdict();
      end
      if (!rst && tx !== lvl)
      begin
         // a long passive segment is the gap before a frame, not a bit
         if (mon_en && (lvl ? len == T_SOF_US : len >= T_EOD_US)) nb = 0;
         else if (mon_en)
         begin
            if (len != 64 && len != 128) check(len, 64);
            sh = {sh[6:0], (len == 64) ? lvl : ~lvl};
            nb++;
            if (nb % 8 == 0) check(sh, exp_q.pop_front());
         end
         lvl = tx;
         len = 1;
      end
      else len++;
   end
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      rst <= 1'b1; hsel <= 1'b0; hwrite <= 1'b0; htrans <= 2'h0; haddr <= '0; hwdata <= '0;
      lvl = 1'b0; mon_en = 1'b1; sh = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      ahb(ADDR_STATUS, 1'b0, 0); check(rd, 32'h2);
      ahb(ADDR_CTRL, 1'b0, 0); check(rd, 32'h0);
      ahb(12'hFF0, 1'b0, 0); check(rd, 32'h0);
      repeat (400) @(posedge clk);
      b = 16'($random(seed));
      exp_q.push_back(b[15:8]); exp_q.push_back(b[7:0]); exp_q.push_back(crc8(b, 16));
      ahb(ADDR_DATA, 1'b1, {24'h0, b[15:8]});
      repeat (20) @(posedge clk);
      ahb(ADDR_DATA, 1'b1, {23'h0, 1'b1, b[7:0]});
      repeat (3700) @(posedge clk);
      ahb(ADDR_STATUS, 1'b0, 0); check(rd[4:2], 32'h1);
      check(exp_q.size(), 0);
      ahb(ADDR_STATUS, 1'b1, 32'h3D);
      for (int k = 0; k < 2; k++)
      begin
         b[15:8] = 8'($random(seed));
         b[7:0] = crc8({8'h00, b[15:8]}, 8) ^ 8'(k);
         vpw_node_model_i.send(b, 16, 1'b0, 1);
         repeat (400) @(posedge clk);
         ahb(ADDR_STATUS, 1'b0, 0); check(rd[4:2], {1'b0, k[0], 1'b1});
         ahb(ADDR_STATUS, 1'b1, 32'h3D);
      end
      for (int f = 0; f < 2; f++)
      begin
         ahb(ADDR_CTRL, 1'b1, 32'(f));
         vpw_node_model_i.send(16'($random(seed)), 8, 1'b1, f ? 4 : 1);
         repeat (400) @(posedge clk);
         ahb(ADDR_STATUS, 1'b0, 0); check(rd[4], 1);
         ahb(ADDR_CTRL, 1'b0, 0); check(rd[0], 0);
         ahb(ADDR_STATUS, 1'b1, 32'h3D);
      end
      mon_en = 1'b0;
      ahb(ADDR_DATA, 1'b1, 32'h1A5);
      repeat (300) @(posedge clk);
      vpw_node_model_i.hold(1'b1, 300);
      vpw_node_model_i.hold(1'b0, 50);
      check(tx, 0);
      ahb(ADDR_STATUS, 1'b0, 0); check(rd[5], 1);
      // software regains the bus with a top-priority byte once the bus is idle
      mon_en = 1'b1;
      exp_q.push_back(8'h00);
      exp_q.push_back(crc8(16'h0000, 8));
      ahb(ADDR_DATA, 1'b1, 32'h100);
      repeat (3000) @(posedge clk);
      check(exp_q.size(), 0);
      print_verdict();
   end
endmodule : vpw_symbol_crc_codec_tb
